//--- shared/xbm_params.svh
// Constants for the external memory bus master
// How it works
// - Address pins carry low-order internal address bits
// - Multiplexed mode shares the lower 16 address lines with data
// - Burst pending high while another beat follows
// - One of four bank selects marks target
// - Output enable only for bank-select read accesses
// - Data lines: device drives non-multiplexed writes, memory reads
// - Read/write indicator driven for every transaction
`ifndef XBM_PARAMS_SVH
`define XBM_PARAMS_SVH
`define XBM_ADDR_PINS 22
`define XBM_DATA_W 32
`define XBM_MUX_W 16
`define XBM_BANKS 4
`define XBM_CLK_PERIOD_NS 5
`define XBM_ACCESS_NS 20
`define XBM_WAIT_CYCLES ((`XBM_ACCESS_NS + `XBM_CLK_PERIOD_NS - 1) / `XBM_CLK_PERIOD_NS)
`define XBM_STEP_32 22'h000004
`define XBM_STEP_16 22'h000002
`define XBM_RD_LEVEL 1'b1
`define XBM_WR_LEVEL 1'b0
`define XBM_ASSERT_N 1'b0
`define XBM_NEGATE_N 1'b1
`endif

//--- shared/xbm_pkg.sv
// Types for the external memory bus master
package xbm_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [1:0] bank;
    logic [1:0] beats;
  } xbm_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
  } xbm_rd_t;

  typedef enum logic [2:0] {
    XBM_IDLE,
    XBM_ADDR,
    XBM_BEAT,
    XBM_END
  } xbm_state_t;
endpackage : xbm_pkg

//--- logic/xbm_pin_sync.sv
// Three-stage synchroniser for bus pins
`timescale 1ns/1ps
module xbm_pin_sync #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] s2_o,
  output logic [W-1:0] s3_o
);
  logic [W-1:0] s1;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1 <= '0;
      s2_o <= '0;
      s3_o <= '0;
    end
    else
    begin
      s1 <= pin_i;
      s2_o <= s1;
      s3_o <= s2_o;
    end
  end
endmodule : xbm_pin_sync

//--- logic/xbm_bus_master.sv
// External memory bus master: pin sequencing for banked memory
`timescale 1ns/1ps
`include "xbm_params.svh"
module xbm_bus_master #(
  parameter int WAIT_CYCLES = `XBM_WAIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire xbm_pkg::xbm_req_t req_i,
  input wire logic mux_mode_i,
  output logic req_ready_o,
  input wire logic [`XBM_DATA_W-1:0] wdata_i,
  output logic wdata_take_o,
  output xbm_pkg::xbm_rd_t rd_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic [`XBM_ADDR_PINS-1:0] addr_o,
  input wire logic [`XBM_ADDR_PINS-1:0] addr_i,
  output logic addr_oe_n_o,
  output logic [`XBM_DATA_W-1:0] data_o,
  input wire logic [`XBM_DATA_W-1:0] data_i,
  output logic data_oe_n_o,
  output logic ale_o,
  output logic burst_beat_pending_o,
  output logic [`XBM_BANKS-1:0] cs_n_o,
  output logic oe_n_o,
  output logic rd_wr_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  xbm_pkg::xbm_state_t state;
  xbm_pkg::xbm_state_t next_state;
  logic [7:0] cnt;
  logic [1:0] beats_left;
  logic [`XBM_ADDR_PINS-1:0] cur_addr;
  logic is_write;
  logic is_mux;
  logic [1:0] bank;
  logic [`XBM_DATA_W-1:0] d_s2;
  logic [`XBM_DATA_W-1:0] d_s3;
  logic [`XBM_ADDR_PINS-1:0] a_s2;
  logic [`XBM_ADDR_PINS-1:0] a_s3;
  logic take;
  logic stable;
  logic beat_end;
  logic [`XBM_DATA_W-1:0] rd_word;
  logic [`XBM_ADDR_PINS-1:0] step;
  logic [`XBM_DATA_W-1:0] wbeat;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  xbm_pin_sync #(.W(`XBM_DATA_W)) u_dsync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(data_i),
    .s2_o(d_s2),
    .s3_o(d_s3)
  );

  xbm_pin_sync #(.W(`XBM_ADDR_PINS)) u_async (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(addr_i),
    .s2_o(a_s2),
    .s3_o(a_s3)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing
  assign take = (state == xbm_pkg::XBM_IDLE) && req_valid_i;
  assign stable = is_mux ? (a_s2[`XBM_MUX_W-1:0] == a_s3[`XBM_MUX_W-1:0]) : (d_s2 == d_s3);
  assign beat_end = (state == xbm_pkg::XBM_BEAT) && (cnt == 8'h00) && (is_write || stable);
  assign rd_word = is_mux ? {16'h0000, a_s3[`XBM_MUX_W-1:0]} : d_s3;
  assign step = is_mux ? `XBM_STEP_16 : `XBM_STEP_32;

  always_comb
  begin
    next_state = state;
    unique case (state)
      xbm_pkg::XBM_IDLE:
      begin
        if (req_valid_i)
          next_state = mux_mode_i ? xbm_pkg::XBM_ADDR : xbm_pkg::XBM_BEAT;
      end
      xbm_pkg::XBM_ADDR:
        next_state = xbm_pkg::XBM_BEAT;
      xbm_pkg::XBM_BEAT:
      begin
        if (beat_end)
        begin
          if (beats_left != 2'h0)
            next_state = is_mux ? xbm_pkg::XBM_ADDR : xbm_pkg::XBM_BEAT;
          else
            next_state = xbm_pkg::XBM_END;
        end
      end
      xbm_pkg::XBM_END:
        next_state = xbm_pkg::XBM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= xbm_pkg::XBM_IDLE;
    else
      state <= next_state;
  end

  // Wait-state counter, reloaded at every beat start
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= 8'h00;
    else if (next_state == xbm_pkg::XBM_BEAT && (state != xbm_pkg::XBM_BEAT || beat_end))
      cnt <= 8'(WAIT_CYCLES - 1);
    else if (state == xbm_pkg::XBM_BEAT && cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  // Transaction context
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      beats_left <= 2'h0;
      cur_addr <= '0;
      is_write <= 1'b0;
      is_mux <= 1'b0;
      bank <= 2'h0;
    end
    else if (take)
    begin
      beats_left <= req_i.beats;
      cur_addr <= req_i.addr[`XBM_ADDR_PINS-1:0];
      is_write <= req_i.write;
      is_mux <= mux_mode_i;
      bank <= req_i.bank;
    end
    else if (beat_end && beats_left != 2'h0)
    begin
      beats_left <= beats_left - 2'h1;
      cur_addr <= cur_addr + step;
    end
  end

  // Write data fetched at each write beat start
  assign wbeat = wdata_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wdata_take_o <= 1'b0;
    else
      wdata_take_o <= (state == xbm_pkg::XBM_IDLE ? req_i.write : is_write)
        && next_state == xbm_pkg::XBM_BEAT && (state != xbm_pkg::XBM_BEAT || beat_end);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      addr_o <= '0;
      addr_oe_n_o <= `XBM_NEGATE_N;
      ale_o <= 1'b0;
    end
    else if (next_state == xbm_pkg::XBM_ADDR)
    begin
      addr_o <= (state == xbm_pkg::XBM_IDLE) ? req_i.addr[`XBM_ADDR_PINS-1:0]
        : cur_addr + step;
      addr_oe_n_o <= `XBM_ASSERT_N;
      ale_o <= 1'b1;
    end
    else if (next_state == xbm_pkg::XBM_BEAT)
    begin
      ale_o <= 1'b0;
      if (state == xbm_pkg::XBM_IDLE)
      begin
        addr_o <= req_i.addr[`XBM_ADDR_PINS-1:0];
        addr_oe_n_o <= `XBM_ASSERT_N;
      end
      else if (beat_end && !is_mux)
        addr_o <= cur_addr + step;
      if (is_mux && state == xbm_pkg::XBM_ADDR)
      begin
        addr_oe_n_o <= is_write ? `XBM_ASSERT_N : `XBM_NEGATE_N;
        if (is_write)
          addr_o[`XBM_MUX_W-1:0] <= wbeat[`XBM_MUX_W-1:0];
      end
    end
    else
    begin
      ale_o <= 1'b0;
      addr_oe_n_o <= `XBM_NEGATE_N;
    end
  end

  // Data lines driven only for non-multiplexed writes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_o <= '0;
      data_oe_n_o <= `XBM_NEGATE_N;
    end
    else if (next_state == xbm_pkg::XBM_BEAT && (state != xbm_pkg::XBM_BEAT || beat_end))
    begin
      data_o <= wbeat;
      data_oe_n_o <= ((state == xbm_pkg::XBM_IDLE ? req_i.write : is_write)
        && !(state == xbm_pkg::XBM_IDLE ? mux_mode_i : is_mux))
        ? `XBM_ASSERT_N : `XBM_NEGATE_N;
    end
    else if (next_state != xbm_pkg::XBM_BEAT)
      data_oe_n_o <= `XBM_NEGATE_N;
  end

  // Bank select, output enable, direction, burst pending
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_n_o <= {`XBM_BANKS{`XBM_NEGATE_N}};
      oe_n_o <= `XBM_NEGATE_N;
      rd_wr_o <= `XBM_RD_LEVEL;
      burst_beat_pending_o <= 1'b0;
    end
    else if (take)
    begin
      cs_n_o <= ~(4'h1 << req_i.bank);
      oe_n_o <= (!req_i.write && !mux_mode_i) ? `XBM_ASSERT_N : `XBM_NEGATE_N;
      rd_wr_o <= req_i.write ? `XBM_WR_LEVEL : `XBM_RD_LEVEL;
      burst_beat_pending_o <= req_i.beats != 2'h0;
    end
    else
    begin
      if (state == xbm_pkg::XBM_ADDR)
        oe_n_o <= is_write ? `XBM_NEGATE_N : `XBM_ASSERT_N;
      else if (next_state == xbm_pkg::XBM_ADDR)
        oe_n_o <= `XBM_NEGATE_N;
      // Pending follows every beat end, also those that reopen an address phase
      if (beat_end)
      begin
        burst_beat_pending_o <= beats_left > 2'h1;
        if (beats_left == 2'h0)
        begin
          cs_n_o <= {`XBM_BANKS{`XBM_NEGATE_N}};
          oe_n_o <= `XBM_NEGATE_N;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User side
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_o <= '0;
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      req_ready_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= beat_end && !is_write;
      if (beat_end && !is_write)
      begin
        rd_o.data <= rd_word;
        rd_o.last <= beats_left == 2'h0;
      end
      done_o <= state == xbm_pkg::XBM_END;
      req_ready_o <= next_state == xbm_pkg::XBM_IDLE && !take;
    end
  end
endmodule : xbm_bus_master

//--- tb/xbm_checker.sv
// Pin protocol checks for the bus master
`timescale 1ns/1ps
module xbm_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire xbm_pkg::xbm_req_t req_i,
  input wire logic mux_mode_i,
  input wire logic req_ready_o,
  input wire xbm_pkg::xbm_rd_t rd_o,
  input wire logic rd_valid_o,
  input wire logic done_o,
  input wire logic [21:0] addr_o,
  input wire logic addr_oe_n_o,
  input wire logic data_oe_n_o,
  input wire logic ale_o,
  input wire logic burst_beat_pending_o,
  input wire logic [3:0] cs_n_o,
  input wire logic oe_n_o,
  input wire logic rd_wr_o
);
  logic [1:0] beats_req;
  logic [1:0] beats_seen;

  // Beats asked for and read beats delivered in the current transaction
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      beats_req <= 2'h0;
      beats_seen <= 2'h0;
    end
    else if (req_valid_i && req_ready_o)
    begin
      beats_req <= req_i.beats;
      beats_seen <= 2'h0;
    end
    else if (rd_valid_o)
      beats_seen <= beats_seen + 2'h1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    req_valid_i && req_ready_o;
  endsequence
  sequence sel_s;
    cs_n_o == ~(4'h1 << $past(req_i.bank)) && addr_o == $past(req_i.addr[21:0]);
  endsequence
  bank_sel_a: assert property (take_s |=> sel_s)
    else $error("bank select or address");
  rw_level_a: assert property (take_s |=> rd_wr_o == !$past(req_i.write))
    else $error("rd_wr level");
  one_bank_a: assert property ($onehot0(~cs_n_o))
    else $error("several banks");
  oe_read_a: assert property (!oe_n_o |-> cs_n_o != 4'hF && rd_wr_o)
    else $error("oe outside bank read");
  no_clash_a: assert property (!data_oe_n_o |-> oe_n_o)
    else $error("data clash");
  ale_phase_a: assert property (ale_o |-> !addr_oe_n_o && oe_n_o ##1 !ale_o)
    else $error("ale phase");
  ale_mode_a: assert property (take_s |=> ale_o == $past(mux_mode_i))
    else $error("ale mode");
  pend_on_a: assert property ((take_s and req_i.beats != 2'h0) |=> burst_beat_pending_o)
    else $error("pending missing");
  pend_off_a: assert property ((take_s and req_i.beats == 2'h0) |=> !burst_beat_pending_o [*3])
    else $error("pending single");
  pend_mid_a: assert property (rd_valid_o && !rd_o.last |->
    burst_beat_pending_o == ({1'b0, beats_seen} + 3'h1 < {1'b0, beats_req}))
    else $error("pending after middle beat");
  addr_drive_a: assert property (take_s |=> !addr_oe_n_o)
    else $error("address lines not driven");
  last_beat_a: assert property (rd_valid_o && rd_o.last |-> !burst_beat_pending_o)
    else $error("pending on last");
  done_in_a: assert property (take_s |-> ##[2:60] done_o)
    else $error("no done");
endmodule : xbm_checker
bind xbm_bus_master xbm_checker i_xbm_checker (.clk_i, .rst_i, .req_valid_i, .req_i,
  .mux_mode_i, .req_ready_o, .rd_o, .rd_valid_o, .done_o, .addr_o, .addr_oe_n_o,
  .data_oe_n_o, .ale_o, .burst_beat_pending_o, .cs_n_o, .oe_n_o, .rd_wr_o);

//--- tb/xbm_memory_model.sv
// Banked memory answering on the bus pins
`timescale 1ns/1ps
module xbm_memory_model (
  input wire logic clk_i,
  input wire logic mux_i,
  input wire logic [1:0] dly_i,
  input wire logic [21:0] addr_i,
  input wire logic ale_i,
  input wire logic [3:0] cs_n_i,
  input wire logic oe_n_i,
  output logic [31:0] data_o
);
  logic [21:0] lat = 22'h0;
  logic [31:0] idle = 32'h0;
  logic [2:0] cnt = 3'h0;
  logic drive;
  always @(posedge clk_i)
  begin
    if (ale_i) lat <= addr_i;
    idle <= ~data_o;
    cnt <= oe_n_i ? 3'h0 : cnt + 3'h1;
  end
  assign drive = !oe_n_i && cs_n_i != 4'hF && cnt >= {1'b0, dly_i};
  assign data_o = drive ? {10'h2B5, mux_i ? lat : addr_i} : idle;
endmodule : xbm_memory_model

//--- tb/test_external_memory_bus_master.sv
// Self-checking bench for the bus master
`timescale 1ns/1ps
module test_external_memory_bus_master;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  xbm_pkg::xbm_req_t req_i = '0;
  logic mux_mode_i = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic [1:0] dly = 2'h0;
  logic req_ready_o, wdata_take_o, rd_valid_o, done_o, addr_oe_n_o, data_oe_n_o;
  logic ale_o, burst_beat_pending_o, oe_n_o, rd_wr_o;
  xbm_pkg::xbm_rd_t rd_o;
  logic [21:0] addr_o, addr_i;
  logic [31:0] data_o, data_i, mem_q;
  logic [3:0] cs_n_o;
  int fails = 0;
  int samples_checked = 0;
  assign addr_i = addr_oe_n_o ? {addr_o[21:16], mem_q[15:0]} : addr_o;
  assign data_i = data_oe_n_o ? mem_q : data_o;
  xbm_bus_master #(.WAIT_CYCLES(4)) i_xbm_bus_master (.clk_i, .rst_i, .req_valid_i, .req_i,
    .mux_mode_i, .req_ready_o, .wdata_i, .wdata_take_o, .rd_o, .rd_valid_o, .done_o,
    .addr_o, .addr_i, .addr_oe_n_o, .data_o, .data_i, .data_oe_n_o, .ale_o,
    .burst_beat_pending_o, .cs_n_o, .oe_n_o, .rd_wr_o);
  xbm_memory_model i_xbm_memory_model (.clk_i, .mux_i(mux_mode_i), .dly_i(dly),
    .addr_i(addr_o), .ale_i(ale_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .data_o(mem_q));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [21:0] a, input logic w, input logic [1:0] b,
    input logic [1:0] n, input logic m);
    logic [21:0] ba;
    int got;
    int tk;
    ba = a;
    got = 0;
    tk = 0;
    while (req_ready_o !== 1'b1) @(posedge clk_i) #1;
    req_i = '{addr: {10'h0, a}, write: w, bank: b, beats: n};
    mux_mode_i = m;
    wdata_i = {a[15:0], ~a[15:0]};
    req_valid_i = 1'b1;
    @(posedge clk_i) #1;
    req_valid_i = 1'b0;
    repeat (80)
    begin
      if (rd_valid_o === 1'b1)
      begin
        chk("rdata", m ? {16'h0, ba[15:0]} : {10'h2B5, ba}, rd_o.data);
        chk("last", {31'h0, got == n}, {31'h0, rd_o.last});
        ba = ba + (m ? 22'h2 : 22'h4);
        got++;
      end
      if (data_oe_n_o === 1'b0) chk("wdata", wdata_i, data_o);
      if (m && w && ale_o === 1'b0 && addr_oe_n_o === 1'b0 && cs_n_o !== 4'hF)
        chk("mux wdata", {16'h0, wdata_i[15:0]}, {16'h0, addr_o[15:0]});
      tk += wdata_take_o;
      if (done_o === 1'b1) break;
      @(posedge clk_i) #1;
    end
    chk("done", 32'h1, {31'h0, done_o});
    chk("beats", {30'h0, n} + 32'h1, w ? tk : got);
  endtask : xfer
  task automatic t_banks;
    for (int i = 0; i < 4; i++)
    begin
      xfer(22'h000100 + 22'(i * 16), i[0], i[1:0], 2'h0, 1'b0);
    end
    $display("test banks end");
  endtask : t_banks
  task automatic t_burst;
    xfer(22'h3FFFF8, 1'b0, 2'h2, 2'h3, 1'b0);
    xfer(22'h001000, 1'b1, 2'h3, 2'h3, 1'b0);
    $display("test burst end");
  endtask : t_burst
  task automatic t_mux;
    xfer(22'h02ABCE, 1'b0, 2'h1, 2'h1, 1'b1);
    xfer(22'h00FFFE, 1'b1, 2'h0, 2'h1, 1'b1);
    $display("test mux end");
  endtask : t_mux
  task automatic t_slow;
    dly = 2'h2;
    xfer(22'h000040, 1'b0, 2'h0, 2'h2, 1'b0);
    dly = 2'h0;
    $display("test slow end");
  endtask : t_slow
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #20000;
    fails++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_banks();
    t_burst();
    t_mux();
    t_slow();
    close_out();
  end
endmodule : test_external_memory_bus_master
